// ==== evseq_pkg.sv ====
// Purpose: shared constants for the event/action rule sequencer
// Assumes: codes are 8-bit selectors from configuration
// Notes: timer counts are in scan ticks
package evseq_pkg;
   localparam int unsigned MAX_SLOTS = 20;
   localparam int unsigned CODE_W = 8;
   localparam int unsigned IDX_W = 5;
   localparam int unsigned TMR_W = 16;
   // event codes
   localparam logic [7:0] EV_FALSE = 8'h00;
   localparam logic [7:0] EV_TRUE = 8'h01;
   localparam logic [7:0] EV_ON_REF = 8'h04;
   localparam logic [7:0] EV_TMR0_OUT = 8'h1E;
   // action codes
   localparam logic [7:0] ACT_NONE = 8'h01;
   localparam logic [7:0] ACT_PRESET0 = 8'h0A;
   localparam logic [7:0] ACT_PRESET1 = 8'h0B;
   localparam logic [7:0] ACT_TMR0_START = 8'h1D;
   // start input function codes
   localparam logic [7:0] DI_START = 8'h08;
   localparam logic [7:0] DI_LATCH_START = 8'h09;
   // second input function codes
   localparam logic [7:0] DI_NOP = 8'h00;
   localparam logic [7:0] DI_STOP_INV = 8'h06;
   typedef enum logic [1:0] {
      EVSEQ_IDLE = 2'b00,
      EVSEQ_RUN = 2'b01
   } evseq_state_t;
   typedef enum logic [1:0] {
      EVSEQ_M_FREE = 2'b00,
      EVSEQ_M_RUN = 2'b01,
      EVSEQ_M_RAMP = 2'b11
   } evseq_motor_t;
endpackage

// ==== evseq_timer.sv ====
// Purpose: timer 0, counts scan ticks after a start action
// Assumes: start and tick are single-cycle pulses
// Notes: expiry flag holds until the next start
`timescale 1ns/1ps
module evseq_timer #(
   parameter int unsigned TMR_W = evseq_pkg::TMR_W
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic start,
   input wire logic tick,
   input wire logic [TMR_W-1:0] duration,
   // status
   output logic expired
);
   logic [TMR_W-1:0] count;
   logic running;
   logic [TMR_W-1:0] next_count;
   logic next_running;
   logic next_expired;

   // reload on start; a zero duration expires at the next tick
   always_comb begin
      next_count = count;
      next_running = running;
      next_expired = expired;
      if (start) begin
         next_count = duration;
         next_running = 1'b1;
         next_expired = 1'b0;
      end else if (running && tick) begin
         if (count == '0) begin
            next_running = 1'b0;
            next_expired = 1'b1;
         end else begin
            next_count = count - 1'b1;
         end
      end
   end

   // state registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
         running <= 1'b0;
         expired <= 1'b0;
      end else begin
         count <= next_count;
         running <= next_running;
         expired <= next_expired;
      end
   end

   chk_timer_expiry: assert property (@(posedge pclk) disable iff (!presetn)
      running && tick && count == '0 && !start |=> expired)
      else $error("timer did not expire at zero count");
endmodule

// ==== evseq_startstop.sv ====
// Purpose: decodes the start/stop digital inputs into a run command
// Assumes: input levels are synchronous to pclk
// Notes: ramp length is a parameter in clock cycles
`timescale 1ns/1ps
module evseq_startstop #(
   parameter int unsigned RAMP_CYC = 16
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // configuration
   input wire logic [7:0] start_func,
   input wire logic [7:0] stop_func,
   // terminals
   input wire logic start_in,
   input wire logic stop_in_n,
   // status
   output logic run_cmd,
   output logic ramping_down,
   output logic motor_free
);
   evseq_pkg::evseq_motor_t mstate;
   evseq_pkg::evseq_motor_t next_mstate;
   logic latched;
   logic next_latched;
   logic [15:0] ramp_cnt;
   logic [15:0] next_ramp_cnt;
   logic want_run;
   logic stop_inv;

   // stop inverse only when the second input is coded for it
   assign stop_inv = (stop_func == evseq_pkg::DI_STOP_INV);

   // start decode: level start or latched start released by stop
   always_comb begin
      next_latched = latched;
      want_run = 1'b0;
      if (start_func == evseq_pkg::DI_START) begin
         want_run = start_in;
         next_latched = 1'b0;
      end else if (start_func == evseq_pkg::DI_LATCH_START) begin
         if (stop_inv && !stop_in_n) begin
            next_latched = 1'b0;
         end else if (start_in) begin
            next_latched = 1'b1;
         end
         want_run = next_latched;
      end else begin
         next_latched = 1'b0;
      end
      // code 0 on the second input does nothing at all
      if (stop_func != evseq_pkg::DI_NOP && stop_inv && !stop_in_n) begin
         want_run = 1'b0;
      end
   end

   // stop ramps down first, then leaves the motor free
   always_comb begin
      next_mstate = mstate;
      next_ramp_cnt = ramp_cnt;
      unique case (mstate)
         evseq_pkg::EVSEQ_M_FREE: begin
            if (want_run) begin
               next_mstate = evseq_pkg::EVSEQ_M_RUN;
            end
         end
         evseq_pkg::EVSEQ_M_RUN: begin
            if (!want_run) begin
               next_mstate = evseq_pkg::EVSEQ_M_RAMP;
               next_ramp_cnt = 16'(RAMP_CYC);
            end
         end
         evseq_pkg::EVSEQ_M_RAMP: begin
            if (want_run) begin
               next_mstate = evseq_pkg::EVSEQ_M_RUN;
            end else if (ramp_cnt <= 16'h0001) begin
               next_mstate = evseq_pkg::EVSEQ_M_FREE;
            end else begin
               next_ramp_cnt = ramp_cnt - 16'h0001;
            end
         end
         default: next_mstate = evseq_pkg::EVSEQ_M_FREE;
      endcase
   end

   // state registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mstate <= evseq_pkg::EVSEQ_M_FREE;
         latched <= 1'b0;
         ramp_cnt <= 16'h0000;
      end else begin
         mstate <= next_mstate;
         latched <= next_latched;
         ramp_cnt <= next_ramp_cnt;
      end
   end

   assign run_cmd = (mstate == evseq_pkg::EVSEQ_M_RUN);
   assign ramping_down = (mstate == evseq_pkg::EVSEQ_M_RAMP);
   assign motor_free = (mstate == evseq_pkg::EVSEQ_M_FREE);

   chk_stop_ramps: assert property (@(posedge pclk) disable iff (!presetn)
      mstate == evseq_pkg::EVSEQ_M_RUN && !want_run |=> ramping_down)
      else $error("stop did not start a ramp down");
   chk_level_start: assert property (@(posedge pclk) disable iff (!presetn)
      start_func == evseq_pkg::DI_START && stop_func == evseq_pkg::DI_NOP
      && start_in && motor_free |=> run_cmd)
      else $error("level start ignored");
   chk_latch_release: assert property (@(posedge pclk) disable iff (!presetn)
      start_func == evseq_pkg::DI_LATCH_START && stop_inv && !stop_in_n |=> !latched)
      else $error("stop inverse did not release latch");
endmodule

// ==== evseq_rule_sequencer.sv ====
// Purpose: event/action rule sequencer with APB configuration
// Assumes: scan_tick is a one-cycle strobe; pclk 25 MHz
// Notes: one slot evaluated per scan tick; zero pairs means idle
//
// Contract
// - an action runs only when its paired event slot evaluates true
// - event n and action n share an index; true advances to n plus one
// - only one event slot is evaluated at a time
// - false event: no action, no other slot, index unchanged
// - on start the sequencer begins at slot zero and waits there
// - zero to twenty event/action pairs may be programmed
// - after the last programmed pair the index wraps to the first
// - runs only while mode is on; otherwise no events or actions
// - event codes: 0 false, 1 true, 4 on reference, 30 timer expired
// - action codes: 1 none, 10 preset 0, 11 preset 1, 29 timer start
// - timer 0 holds a duration; its expiry makes its event true
// - start code 8 is level start; second input code 0 is no operation
// - start code 9 latches; second input code 6 is stop inverse
// - stop ramps the motor down then leaves it free
`timescale 1ns/1ps
module evseq_rule_sequencer #(
   parameter int unsigned NSLOT = evseq_pkg::MAX_SLOTS,
   parameter int unsigned RAMP_CYC = 16
) (
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // drive status
   input wire logic scan_tick,
   input wire logic on_reference,
   // terminals
   input wire logic start_in,
   input wire logic stop_in_n,
   // drive actions
   output logic preset_sel,
   output logic action_strobe,
   output logic [7:0] action_code,
   output logic run_cmd,
   output logic ramping_down,
   output logic motor_free
);
   // register byte offsets
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_TIMER = 12'h004;
   localparam logic [11:0] REG_INPUTS = 12'h008;
   localparam logic [11:0] REG_STATUS = 12'h00C;
   localparam logic [11:0] REG_EVENT0 = 12'h100;
   localparam logic [11:0] REG_ACTION0 = 12'h200;
   localparam logic [11:0] SLOT_SPAN = 12'h050;
   localparam logic [11:0] SLOT_MASK = 12'hF00;
   localparam logic [4:0] CNT_MAX = 5'h14;

   // configuration storage
   logic mode_on;
   logic [4:0] pair_count;
   logic [15:0] tmr_duration;
   logic [7:0] start_func;
   logic [7:0] stop_func;
   logic [7:0] event_code [NSLOT];
   logic [7:0] act_code [NSLOT];
   logic [7:0] next_event_code [NSLOT];
   logic [7:0] next_act_code [NSLOT];
   logic next_mode_on;
   logic [4:0] next_pair_count;
   logic [15:0] next_tmr_duration;
   logic [7:0] next_start_func;
   logic [7:0] next_stop_func;
   // sequencer state
   evseq_pkg::evseq_state_t state;
   evseq_pkg::evseq_state_t next_state;
   logic [4:0] slot;
   logic [4:0] next_slot;
   logic next_preset_sel;
   logic next_action_strobe;
   logic [7:0] next_action_code;
   logic [31:0] next_prdata;
   // helpers
   logic wr_en;
   logic rd_en;
   logic [11:0] base;
   logic [11:0] off;
   logic [4:0] widx;
   logic addr_ok;
   logic ev_true;
   logic tmr_start;
   logic tmr_expired;
   logic [7:0] cur_event;
   logic [7:0] cur_action;

   assign pready = 1'b1; // zero wait states
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign base = paddr & SLOT_MASK;
   assign off = paddr - base;
   assign widx = off[6:2];

   // address decode; unmapped or misaligned accesses flag an error
   always_comb begin
      addr_ok = 1'b0;
      if (paddr[1:0] == 2'b00) begin
         if (paddr == REG_CTRL || paddr == REG_TIMER || paddr == REG_INPUTS
             || paddr == REG_STATUS) begin
            addr_ok = 1'b1;
         end else if ((base == REG_EVENT0 || base == REG_ACTION0) && off < SLOT_SPAN) begin
            addr_ok = 1'b1;
         end
      end
   end
   assign pslverr = psel && penable && !addr_ok;

   // configuration register writes
   always_comb begin
      next_mode_on = mode_on;
      next_pair_count = pair_count;
      next_tmr_duration = tmr_duration;
      next_start_func = start_func;
      next_stop_func = stop_func;
      next_event_code = event_code;
      next_act_code = act_code;
      if (wr_en && addr_ok) begin
         if (paddr == REG_CTRL) begin
            next_mode_on = pwdata[0];
            // counts above the array size are clamped
            next_pair_count = (pwdata[12:8] > CNT_MAX) ? CNT_MAX : pwdata[12:8];
         end else if (paddr == REG_TIMER) begin
            next_tmr_duration = pwdata[15:0];
         end else if (paddr == REG_INPUTS) begin
            next_start_func = pwdata[7:0];
            next_stop_func = pwdata[15:8];
         end else if (base == REG_EVENT0) begin
            next_event_code[widx] = pwdata[7:0];
         end else if (base == REG_ACTION0) begin
            next_act_code[widx] = pwdata[7:0];
         end
      end
   end

   // read data captured in the setup phase
   always_comb begin
      next_prdata = 32'h00000000;
      if (rd_en) begin
         if (!addr_ok) begin
            // misaligned slot reads would otherwise leak a neighbour's code
            next_prdata = 32'h00000000;
         end else if (paddr == REG_CTRL) begin
            next_prdata = {19'h00000, pair_count, 7'h00, mode_on};
         end else if (paddr == REG_TIMER) begin
            next_prdata = {16'h0000, tmr_duration};
         end else if (paddr == REG_INPUTS) begin
            next_prdata = {16'h0000, stop_func, start_func};
         end else if (paddr == REG_STATUS) begin
            next_prdata = {16'h0000, 3'h0, slot, 3'h0, motor_free, ramping_down,
               run_cmd, tmr_expired, preset_sel};
         end else if (base == REG_EVENT0 && off < SLOT_SPAN) begin
            next_prdata = {24'h000000, event_code[widx]};
         end else if (base == REG_ACTION0 && off < SLOT_SPAN) begin
            next_prdata = {24'h000000, act_code[widx]};
         end
      end else begin
         next_prdata = prdata;
      end
   end

   // event decode for the current slot only
   assign cur_event = event_code[slot];
   assign cur_action = act_code[slot];
   always_comb begin
      unique case (cur_event)
         evseq_pkg::EV_FALSE: ev_true = 1'b0;
         evseq_pkg::EV_TRUE: ev_true = 1'b1;
         evseq_pkg::EV_ON_REF: ev_true = on_reference;
         evseq_pkg::EV_TMR0_OUT: ev_true = tmr_expired;
         default: ev_true = 1'b0;
      endcase
   end

   // sequencer: one slot per scan tick, action only on a true event
   always_comb begin
      next_state = state;
      next_slot = slot;
      next_preset_sel = preset_sel;
      next_action_strobe = 1'b0;
      next_action_code = action_code;
      tmr_start = 1'b0;
      unique case (state)
         evseq_pkg::EVSEQ_IDLE: begin
            next_slot = 5'h00;
            if (mode_on && pair_count != 5'h00) begin
               next_state = evseq_pkg::EVSEQ_RUN;
            end
         end
         evseq_pkg::EVSEQ_RUN: begin
            if (!mode_on || pair_count == 5'h00) begin
               next_state = evseq_pkg::EVSEQ_IDLE;
               next_slot = 5'h00;
            end else if (scan_tick && ev_true) begin
               next_action_strobe = 1'b1;
               next_action_code = cur_action;
               if (cur_action == evseq_pkg::ACT_PRESET0) begin
                  next_preset_sel = 1'b0;
               end else if (cur_action == evseq_pkg::ACT_PRESET1) begin
                  next_preset_sel = 1'b1;
               end else if (cur_action == evseq_pkg::ACT_TMR0_START) begin
                  tmr_start = 1'b1;
               end
               // wrap after the last programmed pair
               next_slot = (slot + 5'h01 >= pair_count) ? 5'h00 : slot + 5'h01;
            end
            // a false event leaves slot and outputs alone
         end
         default: next_state = evseq_pkg::EVSEQ_IDLE;
      endcase
   end

   // state registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_on <= 1'b0;
         pair_count <= 5'h00;
         tmr_duration <= 16'h0000;
         start_func <= evseq_pkg::DI_START;
         stop_func <= evseq_pkg::DI_NOP;
         for (int i = 0; i < NSLOT; i++) begin
            event_code[i] <= evseq_pkg::EV_FALSE;
            act_code[i] <= evseq_pkg::ACT_NONE;
         end
         state <= evseq_pkg::EVSEQ_IDLE;
         slot <= 5'h00;
         preset_sel <= 1'b0;
         action_strobe <= 1'b0;
         action_code <= evseq_pkg::ACT_NONE;
         prdata <= 32'h00000000;
      end else begin
         mode_on <= next_mode_on;
         pair_count <= next_pair_count;
         tmr_duration <= next_tmr_duration;
         start_func <= next_start_func;
         stop_func <= next_stop_func;
         event_code <= next_event_code;
         act_code <= next_act_code;
         state <= next_state;
         slot <= next_slot;
         preset_sel <= next_preset_sel;
         action_strobe <= next_action_strobe;
         action_code <= next_action_code;
         prdata <= next_prdata;
      end
   end

   evseq_timer #(.TMR_W(evseq_pkg::TMR_W)) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .start(tmr_start),
      .tick(scan_tick),
      .duration(tmr_duration),
      .expired(tmr_expired)
   );

   evseq_startstop #(.RAMP_CYC(RAMP_CYC)) u_startstop (
      .pclk(pclk),
      .presetn(presetn),
      .start_func(start_func),
      .stop_func(stop_func),
      .start_in(start_in),
      .stop_in_n(stop_in_n),
      .run_cmd(run_cmd),
      .ramping_down(ramping_down),
      .motor_free(motor_free)
   );

   // checks
   chk_action_cause: assert property (@(posedge pclk) disable iff (!presetn)
      action_strobe |-> $past(scan_tick) && $past(ev_true)
      && $past(state) == evseq_pkg::EVSEQ_RUN)
      else $error("action without a true event");
   chk_slot_advance: assert property (@(posedge pclk) disable iff (!presetn)
      state == evseq_pkg::EVSEQ_RUN && mode_on && scan_tick && ev_true
      && slot + 5'h01 < pair_count |=> slot == $past(slot) + 5'h01)
      else $error("slot did not advance");
   chk_false_hold: assert property (@(posedge pclk) disable iff (!presetn)
      state == evseq_pkg::EVSEQ_RUN && mode_on && pair_count != 5'h00 && !ev_true
      |=> $stable(slot) && !action_strobe)
      else $error("false event changed slot");
   chk_no_tick_hold: assert property (@(posedge pclk) disable iff (!presetn)
      state == evseq_pkg::EVSEQ_RUN && mode_on && pair_count != 5'h00
      && !scan_tick |=> $stable(slot))
      else $error("slot moved without tick");
   chk_slot_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      state == evseq_pkg::EVSEQ_RUN && mode_on && scan_tick && ev_true
      && slot + 5'h01 == pair_count |=> slot == 5'h00)
      else $error("slot did not wrap");
   chk_mode_off: assert property (@(posedge pclk) disable iff (!presetn)
      !mode_on |=> !action_strobe ##1 (state == evseq_pkg::EVSEQ_IDLE || mode_on))
      else $error("sequencer active with mode off");
   chk_start_first: assert property (@(posedge pclk) disable iff (!presetn)
      state == evseq_pkg::EVSEQ_IDLE |=> slot == 5'h00)
      else $error("start not at first slot");
   chk_count_limit: assert property (@(posedge pclk) disable iff (!presetn)
      pair_count <= CNT_MAX && slot < CNT_MAX)
      else $error("pair count out of range");
   chk_preset_one: assert property (@(posedge pclk) disable iff (!presetn)
      action_strobe && action_code == evseq_pkg::ACT_PRESET1 |-> preset_sel)
      else $error("preset 1 not selected");
   chk_one_slot: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(slot) |-> slot == 5'h00 || slot == $past(slot) + 5'h01)
      else $error("slot jumped");
   cov_action: cover property (@(posedge pclk) action_strobe);
   cov_wrap: cover property (@(posedge pclk) slot != 5'h00 ##1 slot == 5'h00);
   cov_timer: cover property (@(posedge pclk) tmr_expired && state == evseq_pkg::EVSEQ_RUN);
   cov_ramp: cover property (@(posedge pclk) ramping_down ##1 motor_free);
endmodule

// ==== evseq_drive_model.sv ====
// Purpose: motor-control side model, makes scan ticks and reference status
// Assumes: one scan tick every PERIOD clocks while enabled
// Notes: on_reference follows the bench request one cycle late
`timescale 1ns/1ps
module evseq_drive_model #(
   parameter int unsigned PERIOD = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bench control
   input wire logic tick_en,
   input wire logic ref_in,
   // drive status
   output logic scan_tick,
   output logic on_reference
);
   logic [7:0] cnt;
   // single-cycle strobe, held low while disabled so config is quiet
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 8'h00;
         scan_tick <= 1'b0;
         on_reference <= 1'b0;
      end else begin
         cnt <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
         scan_tick <= tick_en && (cnt == 8'(PERIOD - 1));
         on_reference <= ref_in;
      end
   end
endmodule

// ==== test_event_action_sequencer.sv ====
// Purpose: self-checking bench for the rule sequencer
// Assumes: zero-wait apb slave, ticks every 8 clocks
// Notes: every executed action code is logged by a monitor
`timescale 1ns/1ps
module test_event_action_sequencer;
   localparam int RAMP = 4;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, scan_tick, on_reference, preset_sel, action_strobe;
   logic tick_en = 0, ref_in = 0, start_in = 0, stop_in_n = 1;
   logic run_cmd, ramping_down, motor_free;
   logic [7:0] action_code;
   logic [7:0] seen[$];
   int fails = 0, tests_run = 0, cyc = 0;
   evseq_rule_sequencer #(.NSLOT(20), .RAMP_CYC(RAMP)) i_evseq_rule_sequencer (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scan_tick(scan_tick), .on_reference(on_reference), .start_in(start_in),
      .stop_in_n(stop_in_n), .preset_sel(preset_sel), .action_strobe(action_strobe),
      .action_code(action_code), .run_cmd(run_cmd), .ramping_down(ramping_down),
      .motor_free(motor_free));
   evseq_drive_model i_evseq_drive_model (.pclk(pclk), .presetn(presetn), .tick_en(tick_en),
      .ref_in(ref_in), .scan_tick(scan_tick), .on_reference(on_reference));
   initial begin
      forever #20 pclk = ~pclk;
   end
   // action log and hang guard
   always @(posedge pclk) begin
      cyc++;
      if (action_strobe === 1'b1) seen.push_back(action_code);
      if (cyc == 20000) begin
         fails++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk("wr_err", 32'h0, {31'h0, err});
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge pclk);
         while (scan_tick !== 1'b1) @(posedge pclk);
      end
      repeat (3) @(posedge pclk);
   endtask
   task automatic t_reset();
      apb(1'b0, 12'h00C, 32'h0);
      chk("status", 32'h00000010, rd);
      apb(1'b0, 12'h008, 32'h0);
      chk("inputs", 32'h00000008, rd);
      chk("act_code", 32'h01, {24'h0, action_code});
      apb(1'b0, 12'h040, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, err});
      chk("unmapped_rd", 32'h0, rd);
   endtask
   // preset 0, timer, preset 1, then a false slot that must hold
   task automatic t_example();
      wr(12'h100, 32'h01);
      wr(12'h104, 32'h04);
      wr(12'h108, 32'h1E);
      wr(12'h10C, 32'h00);
      wr(12'h200, 32'h0A);
      wr(12'h204, 32'h1D);
      wr(12'h208, 32'h0B);
      wr(12'h20C, 32'h01);
      wr(12'h004, 32'h2);
      wr(12'h000, 32'h0401);
      seen.delete();
      tick_en <= 1'b1;
      ticks(4);
      chk("n_after_true", 32'd1, seen.size());
      chk("act0", 32'h0A, {24'h0, seen[0]});
      apb(1'b0, 12'h00C, 32'h0);
      chk("slot1", 32'h1, {27'h0, rd[12:8]});
      ref_in <= 1'b1;
      ticks(8);
      chk("n_actions", 32'd3, seen.size());
      chk("act1", 32'h1D, {24'h0, seen[1]});
      chk("act2", 32'h0B, {24'h0, seen[2]});
      chk("preset", 32'h1, {31'h0, preset_sel});
      apb(1'b0, 12'h00C, 32'h0);
      chk("slot3", 32'h3, {27'h0, rd[12:8]});
      tick_en <= 1'b0;
      wr(12'h000, 32'h0400);
      seen.delete();
      tick_en <= 1'b1;
      ticks(3);
      chk("off_none", 32'd0, seen.size());
      tick_en <= 1'b0;
   endtask
   // two true slots wrap; zero pairs idle; count clamps
   task automatic t_wrap();
      wr(12'h104, 32'h01);
      wr(12'h200, 32'h0A);
      wr(12'h204, 32'h0B);
      wr(12'h000, 32'h0201);
      seen.delete();
      tick_en <= 1'b1;
      ticks(3);
      chk("wrap_n", 32'd3, seen.size());
      chk("wrap_a", 32'h0A0B0A, {8'h0, seen[0], seen[1], seen[2]});
      tick_en <= 1'b0;
      wr(12'h000, 32'h0001);
      seen.delete();
      tick_en <= 1'b1;
      ticks(3);
      chk("zero_n", 32'd0, seen.size());
      tick_en <= 1'b0;
      wr(12'h000, 32'h1F00);
      apb(1'b0, 12'h000, 32'h0);
      chk("clamp", 32'h1400, rd);
   endtask
   // level start, then latched start with inverse stop
   task automatic t_startstop();
      start_in <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("lvl_run", 32'h1, {31'h0, run_cmd});
      start_in <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("lvl_ramp", 32'h1, {31'h0, ramping_down});
      repeat (RAMP + 3) @(posedge pclk);
      chk("lvl_free", 32'h1, {31'h0, motor_free});
      wr(12'h008, 32'h0609);
      start_in <= 1'b1;
      @(posedge pclk);
      start_in <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("latch_run", 32'h1, {31'h0, run_cmd});
      stop_in_n <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("stop_ramp", 32'h1, {31'h0, ramping_down});
      repeat (RAMP + 3) @(posedge pclk);
      chk("stop_free", 32'h1, {31'h0, motor_free});
      stop_in_n <= 1'b1;
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_example();
      t_wrap();
      t_startstop();
      print_verdict();
   end
endmodule
